//--- design/scc_dly_if.sv
// Purpose: carries the reference pulse into and out of the delay line
// Assumes: one clock domain
// Notes: ctrl side drives the pulse and tap select
`timescale 1ns/1ns
interface scc_dly_if;
    logic pulse_in;
    logic marginal_in;
    logic [3:0] sel;
    logic pulse_out;
    logic marginal_out;
    modport ctrl (output pulse_in, output marginal_in, output sel,
                  input pulse_out, input marginal_out);
    modport line (input pulse_in, input marginal_in, input sel,
                  output pulse_out, output marginal_out);
endinterface

//--- design/scc_pkg.sv
// Purpose: shared types of the reference capture and calibration block
// Assumes: nothing beyond the register header
// Notes: types only
package scc_pkg;
    typedef enum logic [1:0] {
        SCC_CAL_IDLE,
        SCC_CAL_FG,
        SCC_CAL_BG
    } scc_cal_state_t;
endpackage

//--- design/scc_ref_delay.sv
// Purpose: adjustable delay of the reference pulse and its margin flag
// Assumes: inputs synchronous to aclk
// Notes: select 0 gives two cycles from input to output
`timescale 1ns/1ns
`include "scc_regs.svh"
module scc_ref_delay
    import scc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    scc_dly_if.line dly
);
    logic [`SCC_DLY_TAPS-1:0] pulse_q, pulse_d, marg_q, marg_d;
    logic out_q, out_d, mout_q, mout_d;

    always_comb begin
        pulse_d = {pulse_q[`SCC_DLY_TAPS-2:0], dly.pulse_in};
        marg_d = {marg_q[`SCC_DLY_TAPS-2:0], dly.marginal_in};
        out_d = pulse_q[dly.sel];
        mout_d = marg_q[dly.sel];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= '0;
            marg_q <= '0;
            out_q <= 1'b0;
            mout_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            marg_q <= marg_d;
            out_q <= out_d;
            mout_q <= mout_d;
        end
    end

    assign dly.pulse_out = out_q;
    assign dly.marginal_out = mout_q;

    tap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (dly.pulse_in && dly.sel == 4'h0) ##1 (dly.sel == 4'h0)
        |=> dly.pulse_out)
        else $error("delay tap zero lost the pulse");
endmodule

//--- design/scc_regs.svh
// Purpose: register indices, field positions, reset values and constants
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: definitions only, shared by the delay line and the top module
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_IDX_REF_CTRL 8'h30
`define SCC_IDX_REF_FLAGS 8'h31
`define SCC_IDX_REF_DELAY 8'h32
`define SCC_IDX_CAL_START 8'h50
`define SCC_IDX_CAL_MODE 8'h57
`define SCC_IDX_LINK_CTRL 8'h60
`define SCC_IDX_DECIM 8'h61
`define SCC_IDX_OFFSET 8'h62
`define SCC_IDX_CAL_STATUS 8'h63
`define SCC_IDX_TIMING_CAL 8'h66
`define SCC_BIT_RCVR_EN 7
`define SCC_BIT_PROC_EN 6
`define SCC_BIT_SEEN_CLR 5
`define SCC_BIT_DIRTY_CLR 4
`define SCC_BIT_SEEN 7
`define SCC_BIT_DIRTY 6
`define SCC_BIT_CAL_START 3
`define SCC_BIT_BG_SEL 0
`define SCC_BIT_CONT_SEL 1
`define SCC_BIT_TIMING_EN 0
`define SCC_BIT_LINK_EN 0
`define SCC_RST_BYTE 8'h00
`define SCC_DLY_TAPS 16
`define SCC_CAL_STATIC_CODE 12'h800
`define SCC_LAST_CORE 3'h4
`define SCC_DEC_BYPASS 3'h0
`define SCC_DEC_4 6'h04
`define SCC_DEC_8 6'h08
`define SCC_DEC_10 6'h0a
`define SCC_DEC_16 6'h10
`define SCC_DEC_20 6'h14
`define SCC_DEC_32 6'h20
`define SCC_DEC_ONE 6'h01
`define SCC_RESP_OKAY 2'h0
`define SCC_RESP_SLVERR 2'h2
`endif

//--- design/scc_top.sv
// Purpose: reference pulse capture monitor and converter calibration control
// Assumes: AXI4-Lite slave, byte address = register index times four
// Notes: long calibration counts are parameters for shorter simulation
// What this block does
// - Delay reference pulse by four-bit select
// - Sticky flag on captured delayed rising edge
// - Sticky flag on setup or hold failure
// - Detect-clear bit clears edge flag
// - Failure-clear bit clears failure flag
// - Separate receiver and processing enable bits
// - Reset oscillator phase during lane alignment outside bypass
// - Bypass outputs raw samples every cycle
// - Other factors output I/Q at divided rate
// - Foreground calibration forces static code, no data
// - Start bit begins calibration, clears itself
// - Calibration ends after fixed cycle count
// - Background: five cores, one offline, swap
// - Background swap period fixed, not programmable
// - Offset adjust ignored in background mode
// - Timing calibration off by default, adds time
// - Captured pulse aligns local multiframe boundary
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "scc_regs.svh"
module scc_top
    import scc_pkg::*;
#(
    parameter int unsigned CAL_FG_CYCLES = 102000000,
    parameter int unsigned CAL_FG_TIMING_CYCLES = 227000000,
    parameter int unsigned CAL_BG_INIT_CYCLES = 127500000,
    parameter int unsigned CAL_BG_INIT_TIMING_CYCLES = 283750000,
    parameter int unsigned BG_SWAP_CYCLES = 163200000
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_pulse_in,
    input wire logic ref_capture_marginal,
    input wire logic lane_align_phase,
    input wire logic [11:0] raw_sample,
    input wire logic [14:0] ddc_i_in,
    input wire logic [14:0] ddc_q_in,
    output logic ref_receiver_on,
    output logic lmfc_align,
    output logic osc_phase_reset,
    output logic serial_link_enable,
    output logic [4:0] core_online,
    output logic fifth_core_power,
    output logic cal_busy,
    output logic [11:0] sample_out,
    output logic [14:0] iq_i_out,
    output logic [14:0] iq_q_out,
    output logic data_valid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    scc_dly_if dly ();

    scc_ref_delay u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .dly(dly.line)
    );

    // Register state
    logic [7:0] ctrl_q, ctrl_d;
    logic [3:0] delay_q, delay_d;
    logic [1:0] mode_q, mode_d;
    logic timing_q, timing_d, link_q, link_d;
    logic [2:0] decim_q, decim_d;
    logic [7:0] offset_q, offset_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire, rd_fire, start_req;
    logic [7:0] wr_idx, rd_idx, wr_byte, rd_byte;

    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = !rvalid_q;
    assign wr_idx = s_axi_awaddr[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wr_byte = s_axi_wdata[7:0];
    assign start_req = wr_fire && s_axi_wstrb[0]
        && wr_idx == `SCC_IDX_CAL_START
        && wr_byte[`SCC_BIT_CAL_START];

    // Capture monitor state
    logic seen_q, seen_d, dirty_q, dirty_d, prev_q, prev_d;
    logic lmfc_q, lmfc_d, edge_seen;

    // Calibration state
    scc_cal_state_t state_q, state_d;
    logic [29:0] cnt_q, cnt_d, swap_q, swap_d;
    logic [2:0] off_q, off_d;
    logic start_q, start_d, bg_sel;

    assign bg_sel = mode_q[`SCC_BIT_BG_SEL] && mode_q[`SCC_BIT_CONT_SEL];

    always_comb begin
        ctrl_d = ctrl_q;
        delay_d = delay_q;
        mode_d = mode_q;
        timing_d = timing_q;
        link_d = link_q;
        decim_d = decim_q;
        offset_d = offset_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        if (wr_fire) begin
            bvalid_d = 1'b1;
            bresp_d = `SCC_RESP_OKAY;
            case (wr_idx)
                `SCC_IDX_REF_CTRL: if (s_axi_wstrb[0]) ctrl_d = wr_byte;
                `SCC_IDX_REF_DELAY: if (s_axi_wstrb[0]) delay_d = wr_byte[3:0];
                `SCC_IDX_CAL_MODE: if (s_axi_wstrb[0]) mode_d = wr_byte[1:0];
                `SCC_IDX_TIMING_CAL: if (s_axi_wstrb[0]) begin
                    timing_d = wr_byte[`SCC_BIT_TIMING_EN];
                end
                `SCC_IDX_LINK_CTRL: if (s_axi_wstrb[0]) begin
                    link_d = wr_byte[`SCC_BIT_LINK_EN];
                end
                `SCC_IDX_DECIM: if (s_axi_wstrb[0]) decim_d = wr_byte[2:0];
                `SCC_IDX_OFFSET: if (s_axi_wstrb[0]) offset_d = wr_byte;
                `SCC_IDX_CAL_START, `SCC_IDX_REF_FLAGS,
                `SCC_IDX_CAL_STATUS: bresp_d = `SCC_RESP_OKAY;
                default: bresp_d = `SCC_RESP_SLVERR;
            endcase
        end
    end

    always_comb begin
        rd_byte = `SCC_RST_BYTE;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = `SCC_RESP_OKAY;
            case (rd_idx)
                `SCC_IDX_REF_CTRL: rd_byte = ctrl_q;
                `SCC_IDX_REF_FLAGS: rd_byte = {seen_q, dirty_q, 6'h00};
                `SCC_IDX_REF_DELAY: rd_byte = {4'h0, delay_q};
                `SCC_IDX_CAL_START: rd_byte = {4'h0, start_q, 3'h0};
                `SCC_IDX_CAL_MODE: rd_byte = {6'h00, mode_q};
                `SCC_IDX_TIMING_CAL: rd_byte = {7'h00, timing_q};
                `SCC_IDX_LINK_CTRL: rd_byte = {7'h00, link_q};
                `SCC_IDX_DECIM: rd_byte = {5'h00, decim_q};
                `SCC_IDX_OFFSET: rd_byte = offset_q;
                `SCC_IDX_CAL_STATUS: rd_byte = {1'b0, off_q, 2'h0,
                    state_q == SCC_CAL_BG, state_q == SCC_CAL_FG};
                default: rresp_d = `SCC_RESP_SLVERR;
            endcase
            rdata_d = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `SCC_RST_BYTE;
            delay_q <= 4'h0;
            mode_q <= 2'h0;
            timing_q <= 1'b0;
            link_q <= 1'b0;
            decim_q <= `SCC_DEC_BYPASS;
            offset_q <= `SCC_RST_BYTE;
            bvalid_q <= 1'b0;
            bresp_q <= `SCC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `SCC_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            delay_q <= delay_d;
            mode_q <= mode_d;
            timing_q <= timing_d;
            link_q <= link_d;
            decim_q <= decim_d;
            offset_q <= offset_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Reference pulse capture
    assign dly.pulse_in = ref_pulse_in && ctrl_q[`SCC_BIT_RCVR_EN];
    assign dly.marginal_in = ref_capture_marginal
        && ctrl_q[`SCC_BIT_RCVR_EN];
    assign dly.sel = delay_q;
    assign edge_seen = dly.pulse_out && !prev_q;

    always_comb begin
        prev_d = dly.pulse_out;
        // Clear bit held high keeps the flag low
        seen_d = ctrl_q[`SCC_BIT_SEEN_CLR] ? 1'b0
            : (seen_q || edge_seen);
        dirty_d = ctrl_q[`SCC_BIT_DIRTY_CLR] ? 1'b0
            : (dirty_q || (dly.marginal_out && edge_seen));
        lmfc_d = edge_seen && ctrl_q[`SCC_BIT_PROC_EN];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            dirty_q <= 1'b0;
            lmfc_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            seen_q <= seen_d;
            dirty_q <= dirty_d;
            lmfc_q <= lmfc_d;
        end
    end

    assign ref_receiver_on = ctrl_q[`SCC_BIT_RCVR_EN];
    assign lmfc_align = lmfc_q;

    // Calibration sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        swap_d = swap_q;
        off_d = off_q;
        start_d = start_q;
        unique case (state_q)
            SCC_CAL_IDLE, SCC_CAL_BG: begin
                if (start_req) begin
                    state_d = SCC_CAL_FG;
                    start_d = 1'b1;
                    off_d = 3'h0;
                    if (bg_sel) begin
                        cnt_d = timing_q
                            ? 30'(CAL_BG_INIT_TIMING_CYCLES - 1)
                            : 30'(CAL_BG_INIT_CYCLES - 1);
                    end else begin
                        cnt_d = timing_q
                            ? 30'(CAL_FG_TIMING_CYCLES - 1)
                            : 30'(CAL_FG_CYCLES - 1);
                    end
                end else if (state_q == SCC_CAL_BG) begin
                    if (!bg_sel) begin
                        state_d = SCC_CAL_IDLE;
                        off_d = 3'h0;
                    end else if (swap_q == 30'h0) begin
                        // Offline core rotates; swap period fixed
                        swap_d = 30'(BG_SWAP_CYCLES - 1);
                        off_d = (off_q == `SCC_LAST_CORE) ? 3'h0
                            : 3'(off_q + 3'h1);
                    end else begin
                        swap_d = 30'(swap_q - 30'h1);
                    end
                end
            end
            SCC_CAL_FG: begin
                if (cnt_q == 30'h0) begin
                    start_d = 1'b0;
                    swap_d = 30'(BG_SWAP_CYCLES - 1);
                    state_d = bg_sel ? SCC_CAL_BG : SCC_CAL_IDLE;
                end else begin
                    cnt_d = 30'(cnt_q - 30'h1);
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SCC_CAL_IDLE;
            cnt_q <= 30'h0;
            swap_q <= 30'h0;
            off_q <= 3'h0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            swap_q <= swap_d;
            off_q <= off_d;
            start_q <= start_d;
        end
    end

    // Four cores serve in idle, none in foreground calibration; fifth powers up in background mode
    always_comb begin
        core_online = 5'h0f;
        if (state_q == SCC_CAL_FG) begin
            core_online = 5'h00;
        end else if (state_q == SCC_CAL_BG) begin
            core_online = 5'h1f & ~(5'h01 << off_q);
        end
    end
    assign fifth_core_power = state_q == SCC_CAL_BG;
    assign cal_busy = state_q == SCC_CAL_FG;
    assign serial_link_enable = link_q;

    // Output data path
    function automatic logic [5:0] scc_factor(input logic [2:0] sel);
        case (sel)
            3'h1: scc_factor = `SCC_DEC_4;
            3'h2: scc_factor = `SCC_DEC_8;
            3'h3: scc_factor = `SCC_DEC_10;
            3'h4: scc_factor = `SCC_DEC_16;
            3'h5: scc_factor = `SCC_DEC_20;
            3'h6: scc_factor = `SCC_DEC_32;
            default: scc_factor = `SCC_DEC_ONE;
        endcase
    endfunction

    logic [5:0] factor, dcnt_q, dcnt_d;
    logic [11:0] adj, smp_q, smp_d;
    logic [14:0] iq_i_q, iq_i_d, iq_q_q, iq_q_d;
    logic valid_q, valid_d, osc_q, osc_d;

    assign factor = scc_factor(decim_q);
    // Offset applies only outside background mode
    assign adj = bg_sel ? raw_sample
        : 12'(raw_sample + {{4{offset_q[7]}}, offset_q});

    always_comb begin
        smp_d = smp_q;
        iq_i_d = iq_i_q;
        iq_q_d = iq_q_q;
        valid_d = 1'b0;
        dcnt_d = dcnt_q;
        osc_d = lane_align_phase && factor != `SCC_DEC_ONE;
        if (state_q == SCC_CAL_FG) begin
            smp_d = `SCC_CAL_STATIC_CODE;
            iq_i_d = 15'h0000;
            iq_q_d = 15'h0000;
            dcnt_d = 6'h00;
        end else if (factor == `SCC_DEC_ONE) begin
            smp_d = adj;
            valid_d = 1'b1;
            dcnt_d = 6'h00;
        end else if (dcnt_q == 6'h00) begin
            iq_i_d = ddc_i_in;
            iq_q_d = ddc_q_in;
            valid_d = 1'b1;
            dcnt_d = 6'(factor - 6'h01);
        end else begin
            dcnt_d = 6'(dcnt_q - 6'h01);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_q <= 12'h000;
            iq_i_q <= 15'h0000;
            iq_q_q <= 15'h0000;
            valid_q <= 1'b0;
            dcnt_q <= 6'h00;
            osc_q <= 1'b0;
        end else begin
            smp_q <= smp_d;
            iq_i_q <= iq_i_d;
            iq_q_q <= iq_q_d;
            valid_q <= valid_d;
            dcnt_q <= dcnt_d;
            osc_q <= osc_d;
        end
    end

    assign sample_out = smp_q;
    assign iq_i_out = iq_i_q;
    assign iq_q_out = iq_q_q;
    assign data_valid = valid_q;
    assign osc_phase_reset = osc_q;

    seen_set_a: assert property (edge_seen
        && !ctrl_q[`SCC_BIT_SEEN_CLR]
        |=> seen_q ##1 (seen_q || ctrl_q[`SCC_BIT_SEEN_CLR]))
        else $error("edge flag not set by captured edge");
    seen_clear_a: assert property (ctrl_q[`SCC_BIT_SEEN_CLR]
        ##1 ctrl_q[`SCC_BIT_SEEN_CLR] |-> !seen_q)
        else $error("edge flag not held clear");
    dirty_set_a: assert property (edge_seen && dly.marginal_out
        && !ctrl_q[`SCC_BIT_DIRTY_CLR] |=> dirty_q)
        else $error("failure flag not set");
    dirty_clear_a: assert property (ctrl_q[`SCC_BIT_DIRTY_CLR]
        |=> !dirty_q)
        else $error("failure flag not cleared");
    lmfc_pulse_a: assert property (edge_seen
        && ctrl_q[`SCC_BIT_PROC_EN] |=> lmfc_align)
        else $error("multiframe alignment pulse missing");
    fg_static_a: assert property (state_q == SCC_CAL_FG
        |=> !data_valid && sample_out == `SCC_CAL_STATIC_CODE)
        else $error("data seen during foreground calibration");
    start_clear_a: assert property (state_q == SCC_CAL_FG
        && cnt_q == 30'h0 |=> !start_q && state_q != SCC_CAL_FG)
        else $error("start bit did not clear at end");
    fg_count_a: assert property (start_req && state_q == SCC_CAL_IDLE
        && !bg_sel && timing_q |=> cnt_q == 30'(CAL_FG_TIMING_CYCLES - 1))
        else $error("timing calibration count wrong");
    one_offline_a: assert property (state_q == SCC_CAL_BG
        |-> $countones(core_online) == 4 && fifth_core_power)
        else $error("background mode must leave one core offline");
    bypass_rate_a: assert property (state_q == SCC_CAL_IDLE
        && decim_q == `SCC_DEC_BYPASS |=> data_valid)
        else $error("bypass sample missing");
    decim4_gap_a: assert property (data_valid && decim_q == 3'h1
        && $stable(decim_q) && !wr_fire && state_q != SCC_CAL_FG
        |=> !data_valid ##1 !data_valid ##1 (!data_valid || decim_q != 3'h1))
        else $error("divide by four rate wrong");
    offset_off_a: assert property (bg_sel && state_q != SCC_CAL_FG
        && decim_q == `SCC_DEC_BYPASS |=> sample_out == $past(raw_sample))
        else $error("offset applied in background mode");
    osc_reset_a: assert property (lane_align_phase
        && decim_q inside {[3'h1:3'h6]} |=> osc_phase_reset)
        else $error("oscillator reset missing");

    fg_entered_c: cover property (start_req ##1 state_q == SCC_CAL_FG);
    bg_swap_c: cover property (state_q == SCC_CAL_BG && swap_q == 30'h0);
    seen_set_c: cover property (!seen_q ##1 seen_q);
endmodule

//--- testbench/scc_ref_gen.sv
// Purpose: clock generator model that sends the reference pulse
// Assumes: one request cycle gives a four cycle pulse
// Notes: margin line toggles while no pulse is sent
`timescale 1ns/1ns
module scc_ref_gen (
    input wire logic aclk,
    input wire logic fire,
    input wire logic marg,
    output logic pulse,
    output logic marginal
);
    logic [2:0] cnt_q = 3'h0;
    logic tgl_q = 1'b0;
    always @(posedge aclk) begin
        tgl_q <= !tgl_q;
        if (fire) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // Pulse stays synchronous to the device clock
    assign pulse = (cnt_q != 3'h0);
    assign marginal = pulse ? marg : tgl_q;
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench for the capture and calibration block
// Assumes: short calibration counts given as parameters
// Notes: registers reached over AXI4-Lite
`timescale 1ns/1ns
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, marg = 1'b0;
    logic [9:0] awaddr = 10'h0, araddr = 10'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [11:0] raw = 12'h100;
    logic [14:0] ddc_i = 15'h0, ddc_q = 15'h0, iqi, iqq;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, lane = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, rpulse, rmarg, rcv_on, lmfc, osc, busy, dv, fifth;
    logic link;
    logic [1:0] bresp, rresp;
    logic [11:0] smp;
    logic [4:0] cores;
    int n_mismatch = 0, check_count = 0, busy_cnt = 0, vld_cnt = 0, n;
    scc_ref_gen gen (.aclk(aclk), .fire(fire), .marg(marg), .pulse(rpulse),
        .marginal(rmarg));
    scc_top #(.CAL_FG_CYCLES(20), .CAL_FG_TIMING_CYCLES(30),
        .CAL_BG_INIT_CYCLES(25), .CAL_BG_INIT_TIMING_CYCLES(35),
        .BG_SWAP_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ref_pulse_in(rpulse),
        .ref_capture_marginal(rmarg), .lane_align_phase(lane),
        .raw_sample(raw), .ddc_i_in(ddc_i), .ddc_q_in(ddc_q),
        .ref_receiver_on(rcv_on), .lmfc_align(lmfc), .osc_phase_reset(osc),
        .serial_link_enable(link), .core_online(cores),
        .fifth_core_power(fifth), .cal_busy(busy), .sample_out(smp),
        .iq_i_out(iqi), .iq_q_out(iqq), .data_valid(dv));
    initial begin
        forever #5 aclk = !aclk;
    end
    always @(negedge aclk) begin
        busy_cnt <= busy_cnt + int'(busy === 1'b1);
        vld_cnt <= vld_cnt + int'(dv === 1'b1);
    end
    task finish_test;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task axw(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er);
        int i;
        i = 0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && i < 50);
        chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task axr(input logic [7:0] idx, input logic [1:0] er, input logic [7:0] ex);
        int i;
        i = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && i < 50);
        chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
        chk(rdata, {24'h0, ex});
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task t_regs;
        axr(8'h30, 2'h0, 8'h00);
        axr(8'h32, 2'h0, 8'h00);
        axr(8'h66, 2'h0, 8'h00);
        axw(8'h30, 8'hc0, 2'h0);
        axr(8'h30, 2'h0, 8'hc0);
        chk(32'(rcv_on), 32'h1);
        axw(8'h31, 8'hc0, 2'h0);
        axr(8'h31, 2'h0, 8'h00);
        axw(8'h7f, 8'h01, 2'h2);
        axr(8'h7f, 2'h2, 8'h00);
    endtask
    task t_pulse(input logic [3:0] sel, input logic mg);
        axw(8'h32, {4'h0, sel}, 2'h0);
        marg <= mg;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (lmfc !== 1'b1 && n < 40);
        chk(32'(n), 32'(sel) + 32'h4);
        axr(8'h31, 2'h0, {1'b1, mg, 6'h0});
        axw(8'h30, 8'hf0, 2'h0);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (25) @(posedge aclk);
        axr(8'h31, 2'h0, 8'h00);
        axw(8'h30, 8'hc0, 2'h0);
        axr(8'h31, 2'h0, 8'h00);
    endtask
    task t_cal(input logic [7:0] mode, input logic [7:0] tm, input int exp);
        axw(8'h57, mode, 2'h0);
        axw(8'h66, tm, 2'h0);
        busy_cnt = 0;
        axw(8'h50, 8'h08, 2'h0);
        chk({busy, dv, 18'h0, smp}, {2'h2, 18'h0, 12'h800});
        axr(8'h50, 2'h0, 8'h08);
        axw(8'h60, 8'h00, 2'h0);
        axw(8'h60, 8'h01, 2'h0);
        chk(32'(link), 32'h1);
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        repeat (3) @(posedge aclk);
        chk(32'(busy_cnt), 32'(exp));
        axr(8'h50, 2'h0, 8'h00);
        if (mode == 8'h03) begin
            chk(32'(fifth) + 32'($countones(cores)), 32'h5);
            chk(32'(smp), 32'h100);
            axw(8'h57, 8'h00, 2'h0);
        end else begin
            chk(32'(smp), 32'h105);
        end
    endtask
    task t_dec;
        axw(8'h61, 8'h01, 2'h0);
        ddc_i <= 15'h1234;
        ddc_q <= 15'h0567;
        lane <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(osc), 32'h1);
        lane <= 1'b0;
        vld_cnt = 0;
        repeat (40) @(posedge aclk);
        chk(32'(vld_cnt), 32'd10);
        chk({2'h0, iqi, iqq}, {2'h0, 15'h1234, 15'h0567});
        axw(8'h61, 8'h00, 2'h0);
        raw <= 12'h2a0;
        vld_cnt = 0;
        repeat (20) @(posedge aclk);
        chk(32'(vld_cnt), 32'd20);
        chk(32'(smp), 32'h2a5);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_pulse(4'h0, 1'b1);
        t_pulse(4'hf, 1'b0);
        axw(8'h62, 8'h05, 2'h0);
        t_cal(8'h00, 8'h00, 20);
        t_cal(8'h00, 8'h01, 30);
        t_cal(8'h03, 8'h00, 25);
        t_dec;
        finish_test;
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
endmodule
